// ==== hdl/sfv_pkg.sv ====
// package for the serial fifo interrupt vector register bank
// assumes a 32-bit ahb-lite slave window decoded on the low address byte
package sfv_pkg;

	// bank shape
	localparam int unsigned SFV_NUM_REGS = 4;
	localparam int unsigned SFV_REG_W = 16;
	localparam int unsigned SFV_VEC_W = 7;
	localparam int unsigned SFV_NUM_SRC = 8;
	localparam int unsigned SFV_DEC_W = 8;

	// register byte offsets inside the slave window
	localparam logic [7:0] SFV_OFF_CH1_RX = 8'h00;
	localparam logic [7:0] SFV_OFF_CH1_BRK_TX = 8'h04;
	localparam logic [7:0] SFV_OFF_CH2_RX = 8'h08;
	localparam logic [7:0] SFV_OFF_CH2_BRK_TX = 8'h0C;
	localparam logic [7:0] SFV_OFF_LIMIT = 8'h10;

	// field positions
	localparam int unsigned SFV_HI_MSB = 14;
	localparam int unsigned SFV_HI_LSB = 8;
	localparam int unsigned SFV_LO_MSB = 6;
	localparam int unsigned SFV_LO_LSB = 0;
	localparam int unsigned SFV_RSVD_HI = 15;
	localparam int unsigned SFV_RSVD_LO = 7;

	// values after reset and writable bits
	localparam logic [15:0] SFV_REG_RESET = 16'h0000;
	localparam logic [15:0] SFV_WR_MASK = 16'h7F7F;

	// interrupt source indices: register index is bits 2:1, bit 0 picks low field
	localparam logic [2:0] SFV_SRC_CH1_RX_ERR = 3'h0;
	localparam logic [2:0] SFV_SRC_CH1_RX_FULL = 3'h1;
	localparam logic [2:0] SFV_SRC_CH1_BREAK = 3'h2;
	localparam logic [2:0] SFV_SRC_CH1_TX_EMPTY = 3'h3;
	localparam logic [2:0] SFV_SRC_CH2_RX_ERR = 3'h4;
	localparam logic [2:0] SFV_SRC_CH2_RX_FULL = 3'h5;
	localparam logic [2:0] SFV_SRC_CH2_BREAK = 3'h6;
	localparam logic [2:0] SFV_SRC_CH2_TX_EMPTY = 3'h7;

	// ahb-lite codes
	localparam logic [1:0] SFV_HTRANS_IDLE = 2'h0;
	localparam logic [1:0] SFV_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] SFV_HSIZE_BYTE = 3'h0;
	localparam logic [2:0] SFV_HSIZE_HALF = 3'h1;
	localparam logic [2:0] SFV_HSIZE_WORD = 3'h2;
	localparam logic SFV_HRESP_OKAY = 1'b0;

endpackage

// ==== hdl/sfv_vec_reg.sv ====
// one 16-bit vector setting register holding two 7-bit vector fields
// assumes byte lane enables already decoded by the bus slave
`timescale 1ns/100ps
module sfv_vec_reg (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// write side
	input wire logic [1:0] wr_be,
	input wire logic [15:0] wr_data,
	// stored value
	output logic [15:0] image,
	output logic [6:0] hi_vec,
	output logic [6:0] lo_vec
);

	logic [15:0] value_q; // stored bits, reserved ones held at zero

	// reserved bits never store; standby has no path in here at all
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			value_q <= sfv_pkg::SFV_REG_RESET;
		end else begin
			if (wr_be[0]) begin
				value_q[7:0] <= wr_data[7:0] & sfv_pkg::SFV_WR_MASK[7:0];
			end
			if (wr_be[1]) begin
				value_q[15:8] <= wr_data[15:8] & sfv_pkg::SFV_WR_MASK[15:8];
			end
		end
	end

	// field views
	assign image = value_q;
	assign hi_vec = value_q[sfv_pkg::SFV_HI_MSB:sfv_pkg::SFV_HI_LSB];
	assign lo_vec = value_q[sfv_pkg::SFV_LO_MSB:sfv_pkg::SFV_LO_LSB];

	property p_rsvd_zero;
		@(posedge clk) disable iff (!rst_n)
		##1 (value_q[sfv_pkg::SFV_RSVD_HI] == 1'b0) && (value_q[sfv_pkg::SFV_RSVD_LO] == 1'b0);
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit stored a one");

	property p_reset_clear;
		@(posedge clk) disable iff (!rst_n)
		$rose(rst_n) |-> (value_q == 16'h0000);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("register not zero after reset");

	property p_no_write_hold;
		@(posedge clk) disable iff (!rst_n)
		(wr_be == 2'b00) |=> $stable(value_q);
	endproperty
	a_no_write_hold: assert property (p_no_write_hold) else $error("register changed without a write");

endmodule

// ==== hdl/sfv_top.sv ====
// serial fifo channel interrupt vector register bank with ahb-lite slave
// assumes a single-master ahb-lite bus on hclk and a same-clock interrupt accept strobe
//
// Summary of operation
// - four 16-bit read/write registers, reset to zero
// - standby keeps contents; only reset clears
// - bits 15 and 7 ignore writes, read zero
// - seven-bit fields take 0..127, give vectors
// - reg one high field: ch1 receive error
// - reg one low field: ch1 receive full
// - reg two high field: ch1 break
// - reg two low field: ch1 transmit empty
// - reg three high field: ch2 receive error
// - reg three low field: ch2 receive full
// - reg four high field: ch2 break
// - reg four low field: ch2 transmit empty
//
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
module sfv_top #(
	parameter int unsigned ADDR_W = 32
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// power state
	input wire logic standby_mode,
	// interrupt dispatch
	input wire logic irq_accept,
	input wire logic [2:0] irq_source,
	output logic vector_valid,
	output logic [6:0] vector_num
);

	// the decoder needs at least the low address byte
	if (ADDR_W < sfv_pkg::SFV_DEC_W) begin : g_addr_check
		$error("sfv_top: ADDR_W must be at least 8");
	end

	// address phase decode
	wire addr_take; // transfer accepted this cycle
	wire addr_mapped; // offset falls on one of the four registers
	wire [1:0] addr_idx; // register index of the address phase
	wire [1:0] addr_be; // byte lanes of the low half word
	wire [7:0] addr_low; // offset inside the window

	// data phase state
	logic wr_pend_q; // a mapped write is in its data phase
	logic [1:0] wr_idx_q; // target of that write
	logic [1:0] wr_be_q; // lanes of that write
	logic [31:0] hrdata_q; // read data held for the data phase
	logic hreadyout_q; // always ready: zero wait states
	logic hresp_q; // always okay
	logic vector_valid_q; // one-cycle dispatch strobe
	logic [6:0] vector_num_q; // vector number of the last accepted source

	// register bank views
	logic [15:0] reg_img [sfv_pkg::SFV_NUM_REGS]; // stored words
	logic [6:0] hi_vec [sfv_pkg::SFV_NUM_REGS]; // bits 14:8 of each word
	logic [6:0] lo_vec [sfv_pkg::SFV_NUM_REGS]; // bits 6:0 of each word

	// write forwarding for a read right behind a write
	wire [15:0] wr_lane_mask; // lanes being written this cycle
	wire [15:0] wr_next_img; // word the pending write will leave behind
	wire fwd_hit; // read address phase matches the pending write
	wire [15:0] rd_word; // word returned for the read
	wire [31:0] hrdata_d; // next value of the read data register

	// dispatch selection
	wire [6:0] src_vec; // field picked for the accepted source

	// per-source vector fields
	wire [6:0] ch1_rx_error_vector; // reg one bits 14:8
	wire [6:0] ch1_rx_full_vector; // reg one bits 6:0
	wire [6:0] ch1_break_vector; // reg two bits 14:8
	wire [6:0] ch1_tx_empty_vector; // reg two bits 6:0
	wire [6:0] ch2_rx_error_vector; // reg three bits 14:8
	wire [6:0] ch2_rx_full_vector; // reg three bits 6:0
	wire [6:0] ch2_break_vector; // reg four bits 14:8
	wire [6:0] ch2_tx_empty_vector; // reg four bits 6:0

	// a transfer is taken only on a selected nonseq with the bus ready;
	// idle and busy cycles fall through without effect
	assign addr_take = hsel && hready && (htrans == sfv_pkg::SFV_HTRANS_NONSEQ);
	assign addr_low = haddr[sfv_pkg::SFV_DEC_W-1:0];
	assign addr_mapped = (addr_low < sfv_pkg::SFV_OFF_LIMIT);
	assign addr_idx = addr_low[3:2];

	// byte lanes of the 16-bit register inside the word; lanes 2 and 3
	// carry nothing and writes there are dropped
	assign addr_be[0] = (hsize == sfv_pkg::SFV_HSIZE_WORD)
		|| ((hsize == sfv_pkg::SFV_HSIZE_HALF) && !haddr[1])
		|| ((hsize == sfv_pkg::SFV_HSIZE_BYTE) && (haddr[1:0] == 2'h0));
	assign addr_be[1] = (hsize == sfv_pkg::SFV_HSIZE_WORD)
		|| ((hsize == sfv_pkg::SFV_HSIZE_HALF) && !haddr[1])
		|| ((hsize == sfv_pkg::SFV_HSIZE_BYTE) && (haddr[1:0] == 2'h1));

	// data phase bookkeeping for writes; reads need none because the
	// answer is registered at the address phase edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_idx_q <= 2'h0;
			wr_be_q <= 2'h0;
		end else begin
			wr_pend_q <= addr_take && hwrite && addr_mapped && (addr_be != 2'h0);
			wr_idx_q <= addr_take ? addr_idx : wr_idx_q;
			wr_be_q <= addr_take ? addr_be : wr_be_q;
		end
	end

	// forwarding: the register only updates at the end of the write data
	// phase, so a read taken in that same cycle would otherwise see stale data
	assign wr_lane_mask = {{8{wr_be_q[1]}}, {8{wr_be_q[0]}}};
	assign wr_next_img = (reg_img[wr_idx_q] & ~wr_lane_mask)
		| (hwdata[15:0] & wr_lane_mask & sfv_pkg::SFV_WR_MASK);
	assign fwd_hit = wr_pend_q && (wr_idx_q == addr_idx);
	assign rd_word = fwd_hit ? wr_next_img : reg_img[addr_idx];
	// unmapped offsets and upper half word read zero
	assign hrdata_d = (addr_take && !hwrite && addr_mapped) ? {16'h0000, rd_word} : 32'h0000_0000;

	// bus answer registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
			hreadyout_q <= 1'b1;
			hresp_q <= sfv_pkg::SFV_HRESP_OKAY;
		end else begin
			hrdata_q <= hrdata_d;
			hreadyout_q <= 1'b1;
			hresp_q <= sfv_pkg::SFV_HRESP_OKAY;
		end
	end

	// the four vector setting registers; standby_mode reaches none of
	// them, so contents ride through standby untouched
	for (genvar k = 0; k < sfv_pkg::SFV_NUM_REGS; k++) begin : g_reg
		wire [1:0] reg_be; // lanes written into this register
		assign reg_be = (wr_pend_q && (wr_idx_q == 2'(k))) ? wr_be_q : 2'b00;
		sfv_vec_reg u_reg (
			.clk(hclk),
			.rst_n(hresetn),
			.wr_be(reg_be),
			.wr_data(hwdata[15:0]),
			.image(reg_img[k]),
			.hi_vec(hi_vec[k]),
			.lo_vec(lo_vec[k])
		);
	end

	// source to field map: each channel's rx pair sits in one register,
	// its break/tx pair in the next; high field first
	assign ch1_rx_error_vector = hi_vec[0];
	assign ch1_rx_full_vector = lo_vec[0];
	assign ch1_break_vector = hi_vec[1];
	assign ch1_tx_empty_vector = lo_vec[1];
	assign ch2_rx_error_vector = hi_vec[2];
	assign ch2_rx_full_vector = lo_vec[2];
	assign ch2_break_vector = hi_vec[3];
	assign ch2_tx_empty_vector = lo_vec[3];

	// one named leg per source; the index is fully decoded, the last leg is source 7
	assign src_vec = (irq_source == sfv_pkg::SFV_SRC_CH1_RX_ERR) ? ch1_rx_error_vector
		: (irq_source == sfv_pkg::SFV_SRC_CH1_RX_FULL) ? ch1_rx_full_vector
		: (irq_source == sfv_pkg::SFV_SRC_CH1_BREAK) ? ch1_break_vector
		: (irq_source == sfv_pkg::SFV_SRC_CH1_TX_EMPTY) ? ch1_tx_empty_vector
		: (irq_source == sfv_pkg::SFV_SRC_CH2_RX_ERR) ? ch2_rx_error_vector
		: (irq_source == sfv_pkg::SFV_SRC_CH2_RX_FULL) ? ch2_rx_full_vector
		: (irq_source == sfv_pkg::SFV_SRC_CH2_BREAK) ? ch2_break_vector
		: ch2_tx_empty_vector;

	// dispatch: the number is captured at the accept edge and held until
	// the next accept, so a later rewrite never alters a vector in flight
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vector_valid_q <= 1'b0;
			vector_num_q <= 7'h00;
		end else begin
			vector_valid_q <= irq_accept;
			vector_num_q <= irq_accept ? src_vec : vector_num_q;
		end
	end

	// outputs straight from flops
	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
	assign vector_valid = vector_valid_q;
	assign vector_num = vector_num_q;

	// checks

	property p_read_value;
		@(posedge hclk) disable iff (!hresetn)
		(addr_take && !hwrite && addr_mapped) |=> (hrdata_q == {16'h0000, reg_img[$past(addr_idx)]});
	endproperty
	a_read_value: assert property (p_read_value) else $error("read data differs from register");

	property p_read_rsvd;
		@(posedge hclk) disable iff (!hresetn)
		##1 (hrdata_q[15] == 1'b0) && (hrdata_q[7] == 1'b0);
	endproperty
	a_read_rsvd: assert property (p_read_rsvd) else $error("reserved bit read as one");

	property p_unmapped_zero;
		@(posedge hclk) disable iff (!hresetn)
		(addr_take && !addr_mapped) |=> (hrdata_q == 32'h0000_0000) && hreadyout_q && !hresp_q;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped access not answered with zero");

	property p_standby_keep;
		@(posedge hclk) disable iff (!hresetn)
		(standby_mode && !wr_pend_q)
		|=> $stable(reg_img[0]) && $stable(reg_img[1]) && $stable(reg_img[2]) && $stable(reg_img[3]);
	endproperty
	a_standby_keep: assert property (p_standby_keep) else $error("register changed in standby");

	property p_wr_ch1_rx;
		@(posedge hclk) disable iff (!hresetn)
		(wr_pend_q && (wr_idx_q == 2'h0) && (wr_be_q == 2'b11))
		|=> (hi_vec[0] == $past(hwdata[14:8])) && (lo_vec[0] == $past(hwdata[6:0]));
	endproperty
	a_wr_ch1_rx: assert property (p_wr_ch1_rx) else $error("ch1 receive vectors not stored");

	property p_wr_ch1_brk_tx;
		@(posedge hclk) disable iff (!hresetn)
		(wr_pend_q && (wr_idx_q == 2'h1) && (wr_be_q == 2'b11))
		|=> (hi_vec[1] == $past(hwdata[14:8])) && (lo_vec[1] == $past(hwdata[6:0]));
	endproperty
	a_wr_ch1_brk_tx: assert property (p_wr_ch1_brk_tx) else $error("ch1 break/tx vectors not stored");

	property p_wr_ch2_rx;
		@(posedge hclk) disable iff (!hresetn)
		(wr_pend_q && (wr_idx_q == 2'h2) && (wr_be_q == 2'b11))
		|=> (hi_vec[2] == $past(hwdata[14:8])) && (lo_vec[2] == $past(hwdata[6:0]));
	endproperty
	a_wr_ch2_rx: assert property (p_wr_ch2_rx) else $error("ch2 receive vectors not stored");

	property p_wr_ch2_brk_tx;
		@(posedge hclk) disable iff (!hresetn)
		(wr_pend_q && (wr_idx_q == 2'h3) && (wr_be_q == 2'b11))
		|=> (hi_vec[3] == $past(hwdata[14:8])) && (lo_vec[3] == $past(hwdata[6:0]));
	endproperty
	a_wr_ch2_brk_tx: assert property (p_wr_ch2_brk_tx) else $error("ch2 break/tx vectors not stored");

	property p_full_range;
		@(posedge hclk) disable iff (!hresetn)
		(wr_pend_q && (wr_be_q == 2'b11) && (hwdata[14:8] == 7'h7F))
		|=> (hi_vec[$past(wr_idx_q)] == 7'h7F);
	endproperty
	a_full_range: assert property (p_full_range) else $error("vector 127 not accepted");

	property p_dispatch;
		@(posedge hclk) disable iff (!hresetn)
		// the field as it stood at the accept edge: a write landing there is too late
		irq_accept |=> vector_valid_q
			&& (vector_num_q == $past(irq_source[0] ? lo_vec[irq_source[2:1]] : hi_vec[irq_source[2:1]]));
	endproperty
	a_dispatch: assert property (p_dispatch) else $error("wrong vector presented");

	property p_dispatch_hold;
		@(posedge hclk) disable iff (!hresetn)
		!irq_accept |=> !vector_valid_q ##0 $stable(vector_num_q);
	endproperty
	a_dispatch_hold: assert property (p_dispatch_hold) else $error("vector changed without accept");

	property p_always_ready;
		@(posedge hclk) disable iff (!hresetn)
		addr_take |=> hreadyout_q && (hresp_q == sfv_pkg::SFV_HRESP_OKAY);
	endproperty
	a_always_ready: assert property (p_always_ready) else $error("slave inserted a wait or error");

	property p_reset_outputs;
		@(posedge hclk) disable iff (!hresetn)
		$rose(hresetn) |-> (hrdata_q == 32'h0000_0000) && hreadyout_q && !vector_valid_q && (vector_num_q == 7'h00);
	endproperty
	a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not at reset values");

	property p_reset_bank;
		@(posedge hclk) disable iff (!hresetn)
		$rose(hresetn) |-> (reg_img[0] == sfv_pkg::SFV_REG_RESET) && (reg_img[1] == sfv_pkg::SFV_REG_RESET)
			&& (reg_img[2] == sfv_pkg::SFV_REG_RESET) && (reg_img[3] == sfv_pkg::SFV_REG_RESET);
	endproperty
	a_reset_bank: assert property (p_reset_bank) else $error("bank not cleared by reset");

	property p_upper_zero;
		@(posedge hclk) disable iff (!hresetn)
		hrdata_q[31:16] == 16'h0000;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper read half not zero");

	property p_idle_zero;
		@(posedge hclk) disable iff (!hresetn)
		!(addr_take && !hwrite) |=> (hrdata_q == 32'h0000_0000);
	endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("read data left standing");

	property p_unmapped_drop;
		@(posedge hclk) disable iff (!hresetn)
		(addr_take && !addr_mapped) |=> !wr_pend_q;
	endproperty
	a_unmapped_drop: assert property (p_unmapped_drop) else $error("unmapped write reached the bank");

	property p_rsvd_write;
		@(posedge hclk) disable iff (!hresetn)
		(wr_pend_q && (hwdata[15] || hwdata[7]))
		|=> !reg_img[$past(wr_idx_q)][15] && !reg_img[$past(wr_idx_q)][7];
	endproperty
	a_rsvd_write: assert property (p_rsvd_write) else $error("written reserved bit stored");

	property p_lo_full_range;
		@(posedge hclk) disable iff (!hresetn)
		(wr_pend_q && (wr_be_q == 2'b11) && (hwdata[6:0] == 7'h7F))
		|=> (lo_vec[$past(wr_idx_q)] == 7'h7F);
	endproperty
	a_lo_full_range: assert property (p_lo_full_range) else $error("low field 127 not accepted");

	property p_hi_zero;
		@(posedge hclk) disable iff (!hresetn)
		(wr_pend_q && (wr_be_q == 2'b11) && (hwdata[14:8] == 7'h00))
		|=> (hi_vec[$past(wr_idx_q)] == 7'h00);
	endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("high field 0 not accepted");

	property p_okay_always;
		@(posedge hclk) disable iff (!hresetn)
		hresp_q == sfv_pkg::SFV_HRESP_OKAY;
	endproperty
	a_okay_always: assert property (p_okay_always) else $error("error response given");

	property p_ready_always;
		@(posedge hclk) disable iff (!hresetn)
		hreadyout_q;
	endproperty
	a_ready_always: assert property (p_ready_always) else $error("ready dropped");

endmodule

// ==== tb/sfv_cpu_model.sv ====
// cpu-side model: one accept pulse per request, collects the vector
// assumes fire is entered just after a rising hclk edge
`timescale 1ns/100ps
module sfv_cpu_model (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// dispatch answer
	input wire logic vector_valid,
	input wire logic [6:0] vector_num,
	// accept request
	output logic irq_accept,
	output logic [2:0] irq_source
);
	// idle at time zero
	initial begin
		irq_accept = 1'b0;
		irq_source = 3'h0;
	end
	// source flips after the pulse so a stale index never looks valid
	task automatic fire(input logic [2:0] src, output logic [6:0] vec, output logic ok);
		irq_accept <= 1'b1;
		irq_source <= src;
		@(posedge hclk);
		irq_accept <= 1'b0;
		irq_source <= ~src;
		// the answer stands one cycle only, so look in that cycle
		@(negedge hclk);
		ok = (vector_valid === 1'b1);
		vec = vector_num;
		@(posedge hclk);
	endtask
endmodule

// ==== tb/tb.sv ====
// self-checking bench: ahb-lite master tasks plus the cpu dispatch model
// assumes the single slave's hreadyout is fed back as hready
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin fail_count++; $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module tb;
	// one table row: register offset, write value, expected read and fields
	typedef struct packed {logic [7:0] a; logic [15:0] wd; logic [15:0] rd; logic [6:0] hi; logic [6:0] lo;} sfv_row_s;
	logic hclk, hresetn, hsel, hwrite, standby_mode;
	logic [31:0] haddr, hwdata, hrdata, got;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout, hresp, vector_valid, irq_accept;
	logic [6:0] vector_num;
	logic [2:0] irq_source;
	wire hready;
	int fail_count, check_count;
	// field extremes 0 and 127 both in register one, one of them each in registers two and three
	sfv_row_s rows [4] = '{'{sfv_pkg::SFV_OFF_CH1_RX, 16'h7F00, 16'h7F00, 7'h7F, 7'h00},
		'{sfv_pkg::SFV_OFF_CH1_BRK_TX, 16'h0055, 16'h0055, 7'h00, 7'h55},
		'{sfv_pkg::SFV_OFF_CH2_RX, 16'h2A7F, 16'h2A7F, 7'h2A, 7'h7F},
		'{sfv_pkg::SFV_OFF_CH2_BRK_TX, 16'h1301, 16'h1301, 7'h13, 7'h01}};
	// single slave: its ready is the bus ready
	assign hready = hreadyout;
	sfv_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.standby_mode(standby_mode), .irq_accept(irq_accept), .irq_source(irq_source),
		.vector_valid(vector_valid), .vector_num(vector_num));
	sfv_cpu_model cpu (.hclk(hclk), .hresetn(hresetn), .vector_valid(vector_valid), .vector_num(vector_num),
		.irq_accept(irq_accept), .irq_source(irq_source));
	always #12.5 hclk = ~hclk;
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// ready is looked at before the edge, so the edge's own updates cannot race
	task automatic wait_rdy();
		int n;
		n = 0;
		@(negedge hclk);
		while (hready !== 1'b1) begin
			n++;
			if (n > 16) begin
				fail_count++;
				end_of_test();
			end
			@(negedge hclk);
		end
	endtask
	// one single transfer: address phase, then data phase
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [2:0] sz,
		output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= sfv_pkg::SFV_HTRANS_NONSEQ;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		hsize <= sz;
		wait_rdy();
		@(posedge hclk);
		hsel <= 1'b0;
		htrans <= sfv_pkg::SFV_HTRANS_IDLE;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
		`CHK("hresp", sfv_pkg::SFV_HRESP_OKAY, hresp)
		@(posedge hclk);
		// released data line shows the inverse, never the old value
		hwdata <= ~wd;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, sfv_pkg::SFV_HSIZE_WORD, got);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'hA5A5A5A5, sfv_pkg::SFV_HSIZE_WORD, got);
		`CHK("hrdata", exp, got)
	endtask
	task automatic fire_chk(input logic [2:0] s, input logic [6:0] exp);
		logic [6:0] v;
		logic ok;
		cpu.fire(s, v, ok);
		`CHK("vector_valid", 1'b1, ok)
		`CHK("vector_num", exp, v)
	endtask
	initial begin
		{hclk, hresetn, hsel, hwrite, standby_mode, haddr, hwdata, htrans} = '0;
		hsize = sfv_pkg::SFV_HSIZE_WORD;
		fail_count = 0;
		check_count = 0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// software keeps reserved bits 15 and 7 at zero in the table
		foreach (rows[i]) wr(rows[i].a, {16'h0000, rows[i].wd});
		foreach (rows[i]) begin
			rd_chk(rows[i].a, {16'h0000, rows[i].rd});
			fire_chk(3'(2 * i), rows[i].hi);
			fire_chk(3'(2 * i + 1), rows[i].lo);
		end
		$display("test table done");
		// reserved bits and upper lanes ignore ones
		wr(sfv_pkg::SFV_OFF_CH1_BRK_TX, 32'hFFFFFFFF);
		rd_chk(sfv_pkg::SFV_OFF_CH1_BRK_TX, 32'h00007F7F);
		// new high field with both reserved bits set: only the fields move
		wr(sfv_pkg::SFV_OFF_CH1_BRK_TX, 32'h0000A2FF);
		rd_chk(sfv_pkg::SFV_OFF_CH1_BRK_TX, 32'h0000227F);
		$display("test reserved done");
		// unmapped offset reads zero and disturbs nothing
		wr(sfv_pkg::SFV_OFF_LIMIT, 32'h00001111);
		rd_chk(sfv_pkg::SFV_OFF_LIMIT, 32'h00000000);
		rd_chk(sfv_pkg::SFV_OFF_CH1_RX, 32'h00007F00);
		$display("test unmapped done");
		// standby in and out keeps the ch1 tx empty field and registers three and four
		standby_mode <= 1'b1;
		repeat (10) @(posedge hclk);
		fire_chk(sfv_pkg::SFV_SRC_CH1_TX_EMPTY, 7'h7F);
		standby_mode <= 1'b0;
		repeat (3) @(posedge hclk);
		rd_chk(sfv_pkg::SFV_OFF_CH2_RX, 32'h00002A7F);
		rd_chk(sfv_pkg::SFV_OFF_CH2_BRK_TX, 32'h00001301);
		$display("test standby done");
		// second reset in mid-run clears all, the held vector number too
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		`CHK("vector_num", 7'h00, vector_num)
		`CHK("vector_valid", 1'b0, vector_valid)
		`CHK("hreadyout", 1'b1, hreadyout)
		`CHK("hrdata", 32'h00000000, hrdata)
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (rows[i]) rd_chk(rows[i].a, 32'h00000000);
		fire_chk(sfv_pkg::SFV_SRC_CH2_BREAK, 7'h00);
		$display("test reset done");
		end_of_test();
	end
endmodule
